/* include/mid_pkg.sv */
// Shared constants and types for the interrupt dispatch block
package mid_pkg;

  localparam int NUM_SRC = 15;

  // Register map
  localparam logic [7:0] REG_IE       = 8'ha8;
  localparam logic [7:0] REG_EXT_EN   = 8'ha9;
  localparam logic [7:0] REG_PRIO_LO  = 8'hb8;
  localparam logic [7:0] REG_PRIO_HI  = 8'hb9;
  localparam logic [7:0] REG_STATUS   = 8'hba;
  localparam logic [7:0] REG_LATENCY  = 8'hbb;
  localparam logic [7:0] IE_RESET     = 8'h00;
  localparam logic [7:0] EXT_EN_RESET = 8'h00;
  localparam logic [7:0] PRIO_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

  // Field positions and source indices
  localparam int IE_GLOBAL_BIT = 7;
  localparam int IE_LOCAL_BITS = 7;
  localparam int SRC_EXT0      = 0;
  localparam int SRC_EXT1      = 2;
  localparam int SRC_SERIAL    = 6;
  localparam int SRC_RESERVED  = 8;

  // Vector table: base plus fixed eight-byte step per arbitration order
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_SERIAL = 16'h0033;

  // Sources whose pending flag hardware clears when vectoring
  localparam logic [14:0] HW_CLEAR_MASK = 15'h000f;

  // Timing in system clocks
  localparam int DETECT_CYCLES = 1;
  localparam int CALL_CYCLES   = 4;
  localparam int INTERRUPT_RETURN_INSTRUCTION_CYCLES   = 5;
  localparam int DIV_CYCLES    = 8;
  localparam int BEST_CYCLES   = DETECT_CYCLES + CALL_CYCLES;
  localparam int WORST_CYCLES  = DETECT_CYCLES + INTERRUPT_RETURN_INSTRUCTION_CYCLES + DIV_CYCLES + CALL_CYCLES;

  typedef enum logic [1:0] {ST_IDLE, ST_DETECT, ST_CALL} mid_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mid_bus_t;

  typedef struct packed {
    logic insnEnd;
    logic retiEnd;
  } mid_core_t;

  typedef struct packed {
    logic        ext0Pending;
    logic        ext1Pending;
    logic        serialXferDoneFlag;
    logic        writeCollisionFlag;
    logic        modeFaultFlag;
    logic        receiveOverrunFlag;
    logic [10:0] otherPending;
  } mid_flags_t;

endpackage

/* src/mid_dispatch.sv */
// Interrupt dispatch: arbitration, vectoring call sequence and enable registers
`timescale 1ns/1ps
`default_nettype none

module mid_dispatch
  import mid_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire mid_bus_t    regBus,
  output logic      [7:0]  regRdata,
  input  wire mid_core_t   core,
  input  wire mid_flags_t  flags,
  output logic             callActive,
  output logic      [15:0] vectorAddr,
  output logic      [14:0] hwClear
);

  mid_state_t  state;
  logic [7:0]  interrupt_enable;
  logic [7:0]  extEnable;
  logic [7:0]  prioLo;
  logic [7:0]  prioHi;
  logic        inSvcLow;
  logic        inSvcHigh;
  logic        holdoff;
  logic [3:0]  curIdx;
  logic        curHigh;
  logic [1:0]  callCnt;
  logic [7:0]  latCnt;
  logic [7:0]  lastLatency;

  logic [14:0] pending;
  logic [14:0] enables;
  logic [14:0] priority15;
  logic [14:0] requests;
  logic [14:0] eligible;
  logic        anyReq;
  logic [3:0]  winIdx;
  logic        winValid;
  logic        startCall;

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    logic [15:0] off;
    off = VEC_STEP * {12'h000, idx};
    return VEC_BASE + off;
  endfunction

  // Lowest index in the set wins
  function automatic logic [3:0] first_set(input logic [14:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Source map; serial flags are merged here and never cleared by this block
  always_comb begin
    pending                = '0;
    pending[SRC_EXT0]      = flags.ext0Pending;
    pending[SRC_EXT1]      = flags.ext1Pending;
    pending[SRC_SERIAL]    = flags.serialXferDoneFlag | flags.writeCollisionFlag
                           | flags.modeFaultFlag | flags.receiveOverrunFlag;
    pending[1]             = flags.otherPending[0];
    pending[5:3]           = flags.otherPending[3:1];
    pending[7]             = flags.otherPending[4];
    pending[14:9]          = flags.otherPending[10:5];
  end

  always_comb begin
    enables               = {extEnable, interrupt_enable[IE_LOCAL_BITS-1:0]};
    enables[SRC_RESERVED] = 1'b0;
    priority15            = {prioHi, prioLo[IE_LOCAL_BITS-1:0]};
  end

  assign requests = interrupt_enable[IE_GLOBAL_BIT] ? (pending & enables) : '0;
  assign anyReq   = |requests;

  // Running high routine blocks all; running low routine admits only high
  always_comb begin
    if (inSvcHigh) begin
      eligible = '0;
    end else if (inSvcLow) begin
      eligible = requests & priority15;
    end else begin
      eligible = requests;
    end
  end

  always_comb begin
    winValid = |eligible;
    if (|(eligible & priority15)) begin
      winIdx = first_set(eligible & priority15);
    end else begin
      winIdx = first_set(eligible);
    end
  end

  // Vectoring waits for an instruction boundary, so return and divide
  // lengths come straight from the core
  // The boundary that ends a return is skipped, so at least one more
  // instruction runs before a source that is still pending is vectored
  assign startCall = (state == ST_DETECT) && winValid && core.insnEnd
                   && !core.retiEnd;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state   <= ST_IDLE;
      callCnt <= 2'b00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (winValid) begin
            state <= ST_DETECT;
          end
        end
        ST_DETECT: begin
          if (!winValid) begin
            state <= ST_IDLE;
          end else if (startCall) begin
            state   <= ST_CALL;
            callCnt <= 2'(CALL_CYCLES - 1);
          end
        end
        ST_CALL: begin
          if (callCnt == 2'b00) begin
            state <= ST_IDLE;
          end else begin
            callCnt <= callCnt - 2'b01;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign callActive = (state == ST_CALL);

  // Marks the gap between a return and the next boundary, for status
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      holdoff <= 1'b0;
    end else if (core.retiEnd) begin
      holdoff <= 1'b1;
    end else if (core.insnEnd) begin
      holdoff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      curIdx     <= 4'h0;
      curHigh    <= 1'b0;
      vectorAddr <= 16'h0000;
      hwClear    <= '0;
    end else begin
      hwClear <= '0;
      if (startCall) begin
        curIdx     <= winIdx;
        curHigh    <= priority15[winIdx];
        vectorAddr <= vec_of(winIdx);
        hwClear    <= HW_CLEAR_MASK & (15'h0001 << winIdx);
      end
    end
  end

  // A return closes the innermost routine; a new call in that same cycle
  // cannot happen because startCall excludes return completion
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      inSvcLow  <= 1'b0;
      inSvcHigh <= 1'b0;
    end else if (startCall) begin
      if (priority15[winIdx]) begin
        inSvcHigh <= 1'b1;
      end else begin
        inSvcLow <= 1'b1;
      end
    end else if (core.retiEnd) begin
      if (inSvcHigh) begin
        inSvcHigh <= 1'b0;
      end else begin
        inSvcLow <= 1'b0;
      end
    end
  end

  // Response time from detection to last call clock, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      latCnt      <= 8'h00;
      lastLatency <= 8'h00;
    end else if (state == ST_IDLE) begin
      latCnt <= 8'(DETECT_CYCLES);
    end else begin
      if (latCnt != 8'hff) begin
        latCnt <= latCnt + 8'h01;
      end
      if (state == ST_CALL && callCnt == 2'b00) begin
        lastLatency <= latCnt;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      interrupt_enable <= IE_RESET;
      extEnable        <= EXT_EN_RESET;
      prioLo           <= PRIO_RESET;
      prioHi           <= PRIO_RESET;
    end else if (regBus.wr) begin
      case (regBus.addr)
        REG_IE:      interrupt_enable <= regBus.wdata;
        REG_EXT_EN:  extEnable        <= regBus.wdata;
        REG_PRIO_LO: prioLo           <= regBus.wdata;
        REG_PRIO_HI: prioHi           <= regBus.wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (regBus.rd) begin
      case (regBus.addr)
        REG_IE:      regRdata <= interrupt_enable;
        REG_EXT_EN:  regRdata <= extEnable;
        REG_PRIO_LO: regRdata <= prioLo;
        REG_PRIO_HI: regRdata <= prioHi;
        REG_STATUS:  regRdata <= {inSvcHigh, inSvcLow, holdoff, callActive, curIdx};
        REG_LATENCY: regRdata <= lastLatency;
        default:     regRdata <= UNMAPPED_RD;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_call_run;
    callActive [*4] ##1 !callActive;
  endsequence

  sequence s_best_path;
    (state == ST_DETECT && winValid && core.insnEnd && !core.retiEnd)
      ##1 s_call_run;
  endsequence

  property p_detect;
    (state == ST_IDLE && winValid) |=> (state == ST_DETECT);
  endproperty
  a_detect: assert property (p_detect) else $error("request not detected");

  property p_best;
    (state == ST_DETECT && winValid && core.insnEnd && !core.retiEnd)
      |-> s_best_path;
  endproperty
  a_best: assert property (p_best) else $error("call sequence not four clocks");

  property p_interrupt_return_instruction_holdoff;
    core.retiEnd |=> holdoff && !callActive;
  endproperty
  a_interrupt_return_instruction_holdoff: assert property (p_interrupt_return_instruction_holdoff) else $error("vectored right after return");

  property p_no_preempt_high;
    $rose(callActive) |-> !$past(inSvcHigh);
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("high routine preempted");

  property p_ext0;
    $rose(callActive) && curIdx == 4'(SRC_EXT0) |-> hwClear[SRC_EXT0] && vectorAddr == VEC_EXT0;
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext line 0 vector or clear wrong");

  property p_ext1;
    $rose(callActive) && curIdx == 4'(SRC_EXT1) |-> hwClear[SRC_EXT1] && vectorAddr == VEC_EXT1;
  endproperty
  a_ext1: assert property (p_ext1) else $error("ext line 1 vector or clear wrong");

  property p_serial;
    ($rose(callActive) && curIdx == 4'(SRC_SERIAL))
      |-> vectorAddr == VEC_SERIAL && hwClear == '0;
  endproperty
  a_serial: assert property (p_serial) else $error("serial source mishandled");

  property p_global_mask;
    !interrupt_enable[IE_GLOBAL_BIT] |-> !anyReq ##1 (state != ST_DETECT || $past(winValid));
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("request passed global mask");

  property p_vector;
    $rose(callActive) |-> vectorAddr == vec_of(curIdx) && curIdx != 4'(SRC_RESERVED);
  endproperty
  a_vector: assert property (p_vector) else $error("vector address wrong");

  // Vectoring only ever follows a completed instruction that is not a return
  property p_boundary;
    $rose(callActive) |-> $past(core.insnEnd) && !$past(core.retiEnd);
  endproperty
  a_boundary: assert property (p_boundary) else $error("call off boundary");

  property p_level;
    $rose(callActive) |-> (curHigh ? inSvcHigh : inSvcLow);
  endproperty
  a_level: assert property (p_level) else $error("service level not recorded");

  // Equal level requests must not break into a running low routine
  property p_low_wait;
    (inSvcLow && (requests & priority15) == '0) |-> !startCall;
  endproperty
  a_low_wait: assert property (p_low_wait) else $error("low routine entered");

  property p_hw_clear;
    (|hwClear) |-> callActive && $onehot(hwClear) && (hwClear & ~HW_CLEAR_MASK) == '0;
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("flag cleared wrongly");

endmodule // mid_dispatch

`default_nettype wire

/* sim/mid_core_model.sv */
// Behavioural core model: instruction boundaries and returns
`timescale 1ns/1ps
`default_nettype none
module mid_core_model
  import mid_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      callActive,
  output var  mid_core_t core
);
  logic endR    = 1'b0;
  logic retiR   = 1'b0;
  logic freeRun = 1'b0;
  // Core is busy during the call, so no boundary can show then
  assign core = '{insnEnd: (endR | freeRun) & ~callActive, retiEnd: retiR & ~callActive};
  // Cycles under a call do not count toward the instruction
  task automatic exec(input int len, input bit isRet);
    int n;
    n = 0;
    while (n < len) begin
      n = n + 1;
      endR <= (n == len);
      retiR <= isRet && (n == len);
      @(posedge ref_clk);
      if (callActive) n = n - 1;
    end
  endtask
  task automatic stop();
    endR <= 1'b0;
    retiR <= 1'b0;
  endtask
endmodule // mid_core_model
`default_nettype wire

/* sim/mid_dispatch_tb.sv */
// Self-checking bench for the interrupt dispatch block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module mid_dispatch_tb
  import mid_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  mid_bus_t    regBus  = '0;
  logic [7:0]  regRdata;
  mid_core_t   core;
  mid_flags_t  flags;
  logic        callActive;
  logic [15:0] vectorAddr;
  logic [14:0] hwClear;
  logic [14:0] pend    = '0;
  logic [14:0] hwSeen;
  logic [1:0]  serSel  = '0;
  logic [7:0]  rdv;
  int          fails = 0, nCompared = 0, cycles = 0, first, last;

  mid_dispatch u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regBus(regBus),
    .regRdata(regRdata), .core(core), .flags(flags), .callActive(callActive),
    .vectorAddr(vectorAddr), .hwClear(hwClear));
  mid_core_model u_core (.ref_clk(ref_clk), .callActive(callActive), .core(core));

  always #5 ref_clk = ~ref_clk;
  // Peripherals drop flags that hardware clears on vectoring
  always @(posedge ref_clk) if (|hwClear) pend <= pend & ~hwClear;

  function automatic mid_flags_t to_flags(input logic [14:0] s, input logic [1:0] sel);
    mid_flags_t f;
    f = '0;
    f.ext0Pending = s[0];
    f.ext1Pending = s[2];
    f.serialXferDoneFlag = s[6] && sel == 2'h0;
    f.writeCollisionFlag = s[6] && sel == 2'h1;
    f.modeFaultFlag = s[6] && sel == 2'h2;
    f.receiveOverrunFlag = s[6] && sel == 2'h3;
    f.otherPending = {s[14:9], s[7], s[5:3], s[1]};
    return f;
  endfunction
  assign flags = to_flags(pend, serSel);

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regBus <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regBus <= '0;
    @(posedge ref_clk);
    d = regRdata;
  endtask
  // Cycle indices count from the edge that raised the request
  task automatic wait_call(input int lim);
    first = -1;
    last = -1;
    hwSeen = '0;
    for (int k = 1; k <= lim; k++) begin
      @(posedge ref_clk);
      if (callActive === 1'b1) begin
        if (first < 0) first = k - 1;
        last = k - 1;
        hwSeen = hwSeen | hwClear;
      end else if (last >= 0) break;
    end
  endtask
  task automatic interrupt_return_instruction();
    u_core.freeRun <= 1'b0;
    u_core.exec(1, 1'b1);
    u_core.stop();
    @(posedge ref_clk);
  endtask
  task automatic step(input int len, input bit isRet, input logic exp);
    u_core.exec(len, isRet);
    u_core.stop();
    @(posedge ref_clk);
    `CHK("call after instruction", exp, callActive)
  endtask

  task automatic t_regs();
    rd(REG_IE, rdv);
    `CHK("enable reset", IE_RESET, rdv)
    wr(REG_IE, 8'ha5);
    rd(REG_IE, rdv);
    `CHK("enable rw", 8'ha5, rdv)
    rd(8'h00, rdv);
    `CHK("unmapped", UNMAPPED_RD, rdv)
  endtask
  task automatic t_mask();
    u_core.freeRun <= 1'b1;
    wr(REG_IE, 8'h7f);
    pend <= 15'h7eff;
    wait_call(20);
    `CHK("global mask", -1, first)
    wr(REG_IE, 8'h80);
    wait_call(20);
    `CHK("own mask", -1, first)
    pend <= '0;
  endtask
  task automatic t_vectors();
    wr(REG_IE, 8'hff);
    wr(REG_EXT_EN, 8'hff);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == SRC_RESERVED) continue;
      pend <= 15'h1 << i;
      wait_call(20);
      `CHK("best latency", BEST_CYCLES, last)
      `CHK("vector", VEC_BASE + 16'(8 * i), vectorAddr)
      `CHK("hw clear", (i < 4) ? 15'h1 << i : 15'h0, hwSeen)
      pend <= '0;
      interrupt_return_instruction();
      u_core.freeRun <= 1'b1;
    end
  endtask
  task automatic t_serial();
    u_core.freeRun <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      serSel <= 2'(j);
      pend <= 15'h0040;
      step(2, 1'b0, 1'b1);
      `CHK("serial vector", VEC_SERIAL, vectorAddr)
      `CHK("serial kept", 15'h0, hwClear)
      step(1, 1'b1, 1'b0);
      step(3, 1'b0, 1'b1);
      pend <= '0;
      step(1, 1'b1, 1'b0);
    end
  endtask
  task automatic t_worst();
    pend <= 15'h0001;
    fork
      wait_call(40);
      begin
        u_core.exec(7, 1'b1);
        u_core.exec(8, 1'b0);
        u_core.stop();
      end
    join
    `CHK("call after divide", 15, first)
    `CHK("worst latency", WORST_CYCLES, last)
    interrupt_return_instruction();
    rd(REG_LATENCY, rdv);
    `CHK("latency reg", WORST_CYCLES, rdv)
  endtask
  task automatic t_prio();
    wr(REG_PRIO_LO, 8'h04);
    u_core.freeRun <= 1'b1;
    pend <= 15'h0005;
    wait_call(20);
    `CHK("high first", VEC_EXT1, vectorAddr)
    wait_call(20);
    `CHK("high not preempted", -1, first)
    interrupt_return_instruction();
    u_core.freeRun <= 1'b1;
    wait_call(20);
    `CHK("low after return", VEC_EXT0, vectorAddr)
    pend <= 15'h0004;
    wait_call(20);
    `CHK("low preempted", VEC_EXT1, vectorAddr)
    rd(REG_STATUS, rdv);
    `CHK("nested status", {2'b11, 2'b00, 4'(SRC_EXT1)}, rdv)
    interrupt_return_instruction();
    interrupt_return_instruction();
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_mask();
    t_vectors();
    t_serial();
    t_worst();
    t_prio();
    print_verdict();
  end
endmodule // mid_dispatch_tb
`default_nettype wire
